// *** fsb_pkg.sv ***
// Package for the boundary-scan to serial flash bridge
// Function
// - Host programs the flash through the four boundary-scan pins only.
// - Stages run in order: load bridge, write flash, then reconfigure.
// - Bridge hands flash clock, data in, data out and select to scan port.
// - Bridge enters user mode even while config_complete is held low.
// - Data arrives over the scan port, then goes out on the flash pins.
// - After writing, bridge keeps running; no self-started reconfiguration.
// - Reconfiguration request resets the master and drops the bridge.
// - Select doubles as parallel chip enable; data out doubles as DATA[1].
// - Flash clock may come from user_clock_in, at most 40 MHz.
// - Unused chain enable output may float or serve as user I/O.
// - Scan configuration wins over a simultaneous active serial attempt.
// - Configured device drives chain_enable_out_n low for the next device.
package fsb_pkg;
	localparam int FSB_SYNC_STAGES = 2;
	localparam int FSB_BUF_DEPTH = 2;
	localparam int FSB_USER_CLK_MAX_MHZ = 40;
	localparam int FSB_SYS_CLK_MHZ = 100;
	// Minimum user clock period in system cycles, rounded up
	localparam int FSB_USER_CLK_MIN_CYC = (FSB_SYS_CLK_MHZ + FSB_USER_CLK_MAX_MHZ - 1) / FSB_USER_CLK_MAX_MHZ;
	localparam logic FSB_SEL_IDLE = 1'b1;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} fsb_scan_in_t;

	typedef struct packed {
		logic clk;
		logic sel_n;
		logic dout;
	} fsb_flash_out_t;

	typedef enum logic [3:0] {
		FSB_ST_LOAD = 4'h1,
		FSB_ST_RUN = 4'h2,
		FSB_ST_RECONF = 4'h4,
		FSB_ST_HALT = 4'h8
	} fsb_state_t;
endpackage

// *** fsb_buf.sv ***
// Two-entry bit buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module fsb_buf #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	logic [WIDTH-1:0] mem_r [0:1];
	logic wr_ptr_r;
	logic rd_ptr_r;
	logic [1:0] count_r;
	logic push;
	logic pop;

	assign in_ready = (count_r != 2'h2);
	assign out_valid = (count_r != 2'h0);
	assign out_data = mem_r[rd_ptr_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			count_r <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_r <= ~wr_ptr_r;
			end
			if (pop) begin
				rd_ptr_r <= ~rd_ptr_r;
			end
			count_r <= count_r + {1'b0, push} - {1'b0, pop};
		end
	end

	a_buf_no_overflow: assert property (@(posedge clk_sys) disable iff (reset)
		count_r <= 2'h2) else $error("buffer count exceeds two");
endmodule
`default_nettype wire

// *** fsb_bridge.sv ***
// Boundary-scan to serial flash bridge top level
`timescale 1ns/1ns
`default_nettype none
module fsb_bridge (
	input wire logic clk_sys,
	input wire logic reset,
	input wire fsb_pkg::fsb_scan_in_t scan_in,
	output logic scan_tdo,
	input wire logic user_clock_in,
	input wire logic use_user_clock,
	input wire logic flash_serial_input,
	input wire logic reconfig_pulse,
	input wire logic as_config_req,
	input wire logic chain_enable_in_n,
	input wire logic config_complete,
	output var fsb_pkg::fsb_flash_out_t flash_out,
	output logic flash_oe,
	output logic chain_enable_out_n,
	output logic user_mode,
	output logic as_abort,
	output logic reconfig_req
);
	import fsb_pkg::*;

	logic [1:0] tck_s1_r, tck_s2_r;
	logic [3:0] sync1_r, sync2_r;
	logic tck_prev_r, uclk_prev_r;
	fsb_state_t state_r;
	logic tdo_r;
	fsb_flash_out_t fout_r;
	logic oe_r, ceo_n_r, um_r, abort_r, rcfg_r;
	logic bit_valid, bit_ready, q_valid, q_data, q_ready;
	logic tck_rise, tck_fall, shift_en, uclk_rise, flash_tick, flash_busy_r;
	logic [7:0] uclk_gap_r;
	logic tck_s, tms_s, tdi_s, din_s, uclk_s, rcfg_s, as_s, cen_s;

	// Two-flop synchronisers for every pin input except use_user_clock and the unread config_complete
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
			tck_s1_r <= '0;
			tck_s2_r <= '0;
		end else begin
			sync1_r <= {scan_in.tck, scan_in.tms, scan_in.tdi, flash_serial_input};
			sync2_r <= sync1_r;
			tck_s1_r <= {user_clock_in, reconfig_pulse};
			tck_s2_r <= tck_s1_r;
		end
	end
	logic [1:0] misc1_r, misc2_r;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			misc1_r <= 2'h1;
			misc2_r <= 2'h1;
		end else begin
			misc1_r <= {as_config_req, chain_enable_in_n};
			misc2_r <= misc1_r;
		end
	end
	assign {tck_s, tms_s, tdi_s, din_s} = sync2_r;
	assign {uclk_s, rcfg_s} = tck_s2_r;
	assign {as_s, cen_s} = misc2_r;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			tck_prev_r <= 1'b0;
			uclk_prev_r <= 1'b0;
		end else begin
			tck_prev_r <= tck_s;
			uclk_prev_r <= uclk_s;
		end
	end
	assign tck_rise = tck_s && !tck_prev_r;
	assign tck_fall = !tck_s && tck_prev_r;
	assign uclk_rise = uclk_s && !uclk_prev_r;
	// Bit shifting occurs while the host holds tms low in the data phase
	assign shift_en = (state_r == FSB_ST_RUN) && !tms_s;
	assign bit_valid = shift_en && tck_rise;

	// Flash clock pacing: scan clock, or user clock when selected
	assign flash_tick = use_user_clock ? uclk_rise : tck_fall;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			uclk_gap_r <= 8'h00;
		end else if (uclk_rise) begin
			uclk_gap_r <= 8'h00;
		end else if (uclk_gap_r != 8'hFF) begin
			uclk_gap_r <= uclk_gap_r + 8'h01;
		end
	end

	fsb_buf #(.WIDTH(1)) u_buf (
		.clk_sys(clk_sys),
		.reset(reset),
		.in_data(tdi_s),
		.in_valid(bit_valid),
		.in_ready(bit_ready),
		.out_data(q_data),
		.out_valid(q_valid),
		.out_ready(q_ready)
	);
	assign q_ready = flash_tick && !flash_busy_r;

	// Bridge lifecycle
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_r <= FSB_ST_LOAD;
		end else begin
			case (state_r)
				FSB_ST_LOAD: begin
					if (!cen_s) begin
						state_r <= FSB_ST_RUN;
					end
				end
				FSB_ST_RUN: begin
					if (rcfg_s) begin
						state_r <= FSB_ST_RECONF;
					end
				end
				FSB_ST_RECONF: state_r <= FSB_ST_HALT;
				FSB_ST_HALT: state_r <= FSB_ST_HALT;
				default: state_r <= FSB_ST_LOAD;
			endcase
		end
	end

	// Flash pin drive
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			fout_r <= '{clk: 1'b0, sel_n: FSB_SEL_IDLE, dout: 1'b0};
			oe_r <= 1'b0;
			flash_busy_r <= 1'b0;
		end else if (state_r == FSB_ST_RUN) begin
			oe_r <= 1'b1;
			// Select stays low until the clock edge of the last bit has been given
			fout_r.sel_n <= !(q_valid || shift_en || flash_busy_r);
			// Clock rises the cycle after the data changes, so one tick moves a whole bit
			// and the drain keeps pace with the scan side; the clock idles high between bits
			if (q_valid && q_ready) begin
				fout_r.dout <= q_data;
				fout_r.clk <= 1'b0;
				flash_busy_r <= 1'b1;
			end else if (flash_busy_r) begin
				fout_r.clk <= 1'b1;
				flash_busy_r <= 1'b0;
			end
		end else begin
			fout_r <= '{clk: 1'b0, sel_n: FSB_SEL_IDLE, dout: 1'b0};
			oe_r <= 1'b0;
			flash_busy_r <= 1'b0;
		end
	end

	// Returned flash data goes back out on the scan output
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			tdo_r <= 1'b0;
		end else if (state_r == FSB_ST_RUN && tck_fall) begin
			tdo_r <= din_s;
		end
	end

	// Configuration status outputs
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ceo_n_r <= 1'b1;
			um_r <= 1'b0;
			abort_r <= 1'b0;
			rcfg_r <= 1'b0;
		end else begin
			// config_complete is never read: unconfigured slaves may hold it low
			um_r <= (state_r == FSB_ST_RUN);
			ceo_n_r <= !(state_r == FSB_ST_RUN);
			abort_r <= as_s && (state_r != FSB_ST_HALT);
			rcfg_r <= (state_r == FSB_ST_RECONF);
		end
	end

	assign scan_tdo = tdo_r;
	assign flash_out = fout_r;
	assign flash_oe = oe_r;
	assign chain_enable_out_n = ceo_n_r;
	assign user_mode = um_r;
	assign as_abort = abort_r;
	assign reconfig_req = rcfg_r;

	a_idle_select_high: assert property (@(posedge clk_sys) disable iff (reset)
		!oe_r |-> fout_r.sel_n) else $error("select low while idle");
	a_user_mode_low: assert property (@(posedge clk_sys) disable iff (reset)
		um_r |-> !ceo_n_r) else $error("chain enable not low in user mode");
	a_run_no_self: assert property (@(posedge clk_sys) disable iff (reset)
		(state_r == FSB_ST_RUN && !rcfg_s) |=> state_r == FSB_ST_RUN) else $error("left run alone");
	a_reconf_pulse: assert property (@(posedge clk_sys) disable iff (reset)
		(state_r == FSB_ST_RUN && rcfg_s) |=> ##1 rcfg_r ##1 !rcfg_r) else $error("reconfig pulse wrong");
	a_enter_run: assert property (@(posedge clk_sys) disable iff (reset)
		(state_r == FSB_ST_LOAD && !cen_s) |=> ##1 um_r) else $error("no user mode");
	a_abort_as: assert property (@(posedge clk_sys) disable iff (reset)
		(as_s && state_r == FSB_ST_RUN) |=> abort_r) else $error("active serial not aborted");
	a_abort_clear: assert property (@(posedge clk_sys) disable iff (reset)
		!as_s |=> !abort_r) else $error("abort without active serial request");
	a_data_order: assert property (@(posedge clk_sys) disable iff (reset)
		(q_valid && q_ready && state_r == FSB_ST_RUN) |=> fout_r.dout == $past(q_data)) else $error("bit mismatch");
	a_clk_after_data: assert property (@(posedge clk_sys) disable iff (reset)
		(q_valid && q_ready && state_r == FSB_ST_RUN && !rcfg_s) |=> !fout_r.clk ##1 fout_r.clk)
		else $error("flash clock not raised one cycle after data");
	a_sel_at_clk: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(fout_r.clk) |-> !fout_r.sel_n) else $error("flash clock rose while deselected");
	a_halt_final: assert property (@(posedge clk_sys) disable iff (reset)
		state_r == FSB_ST_HALT |=> (state_r == FSB_ST_HALT && !oe_r && fout_r.sel_n))
		else $error("bridge still active after reconfiguration");
	a_oe_in_run: assert property (@(posedge clk_sys) disable iff (reset)
		state_r == FSB_ST_RUN |=> oe_r) else $error("pins not driven");
	c_enter_run: cover property (@(posedge clk_sys) state_r == FSB_ST_RUN);
	c_bit_out: cover property (@(posedge clk_sys) q_valid && q_ready);
	c_reconf: cover property (@(posedge clk_sys) rcfg_r);
	c_buf_full: cover property (@(posedge clk_sys) !bit_ready);
	c_user_clock: cover property (@(posedge clk_sys) use_user_clock && q_valid && q_ready && uclk_gap_r != 8'h00);
endmodule
`default_nettype wire

// *** fsb_host_model.sv ***
// Host model that shifts frames into the scan port
`timescale 1ns/1ns
`default_nettype none
module fsb_host_model (
	output var fsb_pkg::fsb_scan_in_t scan_in
);
	import fsb_pkg::*;
	// Host loads the bridge only into this master, whose straps pick active serial
	initial scan_in = 3'h2;
	// Eight bits MSB first at 80 ns, then a tms-high flush tick; tck stands low between frames
	task automatic send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			scan_in.tms = 1'b0;
			scan_in.tdi = b[i];
			#40 scan_in.tck = 1'b1;
			#40 scan_in.tck = 1'b0;
		end
		scan_in.tms = 1'b1;
		scan_in.tdi = ~b[0];
		#40 scan_in.tck = 1'b1;
		#40 scan_in.tck = 1'b0;
	endtask
endmodule
`default_nettype wire

// *** test_fsb_bridge.sv ***
// Testbench for the boundary-scan to serial flash bridge
`timescale 1ns/1ns
`default_nettype none
module test_fsb_bridge;
	import fsb_pkg::*;
	logic clk_sys, reset, user_clock_in, use_user_clock, flash_serial_input, reconfig_pulse;
	logic as_config_req, chain_enable_in_n, config_complete, uclk_run;
	logic scan_tdo, flash_oe, chain_enable_out_n, user_mode, as_abort, reconfig_req;
	fsb_scan_in_t scan_in;
	fsb_flash_out_t flash_out;
	int n_mismatch, n_checks, n_req, n_sel_hi;
	logic rx_q[$];
	logic [7:0] got;
	fsb_bridge u_fsb_bridge (.clk_sys(clk_sys), .reset(reset), .scan_in(scan_in), .scan_tdo(scan_tdo),
		.user_clock_in(user_clock_in), .use_user_clock(use_user_clock), .flash_serial_input(flash_serial_input),
		.reconfig_pulse(reconfig_pulse), .as_config_req(as_config_req), .chain_enable_in_n(chain_enable_in_n),
		.config_complete(config_complete), .flash_out(flash_out), .flash_oe(flash_oe),
		.chain_enable_out_n(chain_enable_out_n), .user_mode(user_mode), .as_abort(as_abort),
		.reconfig_req(reconfig_req));
	fsb_host_model u_fsb_host_model (.scan_in(scan_in));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// User clock at about 38 MHz, standing still while a stall is wanted
	always #13 if (uclk_run) user_clock_in = ~user_clock_in;
	// Flash side: take data at each clock rise and count rises seen while deselected
	always @(posedge flash_out.clk) begin
		rx_q.push_back(flash_out.dout);
		if (flash_out.sel_n !== 1'b0) n_sel_hi++;
	end
	always @(negedge clk_sys) if (reconfig_req === 1'b1) n_req++;
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wait_um(input logic lvl);
		int i;
		for (i = 0; i < 50 && user_mode !== lvl; i++) @(negedge clk_sys);
		if (i == 50) begin
			n_mismatch++;
			tally_and_finish();
		end
	endtask
	// Sends one frame and gathers the bits seen at flash clock rises, first one in the top bit
	task automatic frame(input logic [7:0] b);
		rx_q.delete();
		u_fsb_host_model.send(b);
		repeat (20) @(negedge clk_sys);
		got = 8'h00;
		foreach (rx_q[i]) if (i < 8) got[7 - i] = rx_q[i];
	endtask
	task automatic t_chain_gate();
		repeat (20) @(negedge clk_sys);
		chk("user_mode_gated", user_mode, 1'b0);
		chk("ceo_n_gated", chain_enable_out_n, 1'b1);
		chain_enable_in_n = 1'b0;
		wait_um(1'b1);
		chk("user_mode_cc_low", user_mode, 1'b1);
		chk("ceo_n_run", chain_enable_out_n, 1'b0);
		chk("oe_run", flash_oe, 1'b1);
	endtask
	task automatic t_stream();
		flash_serial_input = 1'b1;
		frame(8'hA5);
		chk("rx_bits_a5", got, 8'hA5);
		chk("rx_count", 8'(rx_q.size()), 8'd8);
		chk("sel_at_clk", 8'(n_sel_hi), 8'h00);
		chk("tdo_one", scan_tdo, 1'b1);
		flash_serial_input = 1'b0;
		frame(8'h3C);
		chk("rx_bits_3c", got, 8'h3C);
		chk("tdo_zero", scan_tdo, 1'b0);
		chk("no_self_reconf", 8'(n_req), 8'd0);
		chk("still_run", user_mode, 1'b1);
	endtask
	task automatic t_user_clock();
		use_user_clock = 1'b1;
		uclk_run = 1'b1;
		frame(8'h96);
		chk("rx_bits_uclk", got, 8'h96);
		uclk_run = 1'b0;
		frame(8'hC3);
		chk("stall_hold", 8'(rx_q.size()), 8'd0);
		uclk_run = 1'b1;
		repeat (20) @(negedge clk_sys);
		chk("stall_kept", {6'h00, rx_q[0], rx_q[1]}, 8'h03);
		uclk_run = 1'b0;
		use_user_clock = 1'b0;
		frame(8'h5A);
		chk("rx_after_stall", got, 8'h5A);
	endtask
	task automatic t_as_abort();
		as_config_req = 1'b1;
		repeat (10) @(negedge clk_sys);
		chk("as_abort_hi", as_abort, 1'b1);
		chk("scan_wins", user_mode, 1'b1);
		as_config_req = 1'b0;
		repeat (10) @(negedge clk_sys);
		chk("as_abort_lo", as_abort, 1'b0);
	endtask
	task automatic t_reconfig();
		reconfig_pulse = 1'b1;
		repeat (4) @(negedge clk_sys);
		reconfig_pulse = 1'b0;
		repeat (20) @(negedge clk_sys);
		chk("reconf_pulses", 8'(n_req), 8'd1);
		chk("bridge_gone", user_mode, 1'b0);
		chk("oe_off", flash_oe, 1'b0);
		chk("sel_idle", flash_out.sel_n, FSB_SEL_IDLE);
		frame(8'hFF);
		chk("rx_after_reconf", 8'(rx_q.size()), 8'd0);
	endtask
	initial begin
		reset = 1'b1;
		{user_clock_in, use_user_clock, flash_serial_input, reconfig_pulse, as_config_req} = 5'h00;
		// Unconfigured slaves hold config_complete low throughout
		{chain_enable_in_n, config_complete, uclk_run} = 3'h4;
		n_mismatch = 0;
		n_sel_hi = 0;
		n_checks = 0;
		n_req = 0;
		repeat (6) @(negedge clk_sys);
		chk("sel_reset", flash_out.sel_n, FSB_SEL_IDLE);
		chk("oe_reset", flash_oe, 1'b0);
		reset = 1'b0;
		t_chain_gate();
		t_stream();
		t_user_clock();
		t_as_abort();
		t_reconfig();
		tally_and_finish();
	end
endmodule
`default_nettype wire
